/* File: logic/can_ctrl_pkg.sv */
package can_ctrl_pkg;
	// register byte offsets on the apb window
	localparam logic [7:0] OFS_ABORT_REQ = 8'h00;
	localparam logic [7:0] OFS_ABORT_ACK = 8'h04;
	localparam logic [7:0] OFS_BUF_SEL = 8'h08;
	localparam logic [7:0] OFS_FILT_CTRL = 8'h0C;
	localparam logic [7:0] OFS_EMPTY_FLAGS = 8'h10;
	localparam logic [7:0] OFS_MODE_CTRL = 8'h14;
	// field positions
	localparam int MODE_LSB = 4;
	localparam int HIT_LSB = 0;
	localparam int INIT_REQ_BIT = 0;
	localparam int INIT_ACK_BIT = 1;
	// reset values
	localparam logic [2:0] ABORT_REQ_RST = 3'h0;
	localparam logic [2:0] ABORT_ACK_RST = 3'h0;
	localparam logic [2:0] BUF_SEL_RST = 3'h0;
	localparam logic [2:0] EMPTY_RST = 3'h7;
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [2:0] HIT_RST = 3'h0;
	// filter organisation
	localparam logic [1:0] MODE_TWO_32 = 2'h0;
	localparam logic [1:0] MODE_FOUR_16 = 2'h1;
	localparam logic [1:0] MODE_EIGHT_8 = 2'h2;
	localparam logic [1:0] MODE_CLOSED = 2'h3;
	// init handshake takes this many cycles to acknowledge
	localparam int INIT_ACK_DELAY = 2;
endpackage

/* File: logic/can_tx_abort_select_filter_ctrl.sv */
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module can_tx_abort_select_filter_ctrl (
	// clock and reset
	input wire logic clk_in,
	input wire logic nrst_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// transmit engine status, one bit per buffer
	input wire logic [2:0] tx_started_in,
	input wire logic [2:0] tx_success_in,
	input wire logic [2:0] tx_failed_in,
	// receive side
	input wire logic rx_match_in,
	input wire logic [2:0] rx_filter_num_in,
	// window access request from cpu side
	input wire logic win_req_in,
	// outputs to the rest of the controller
	output logic win_allow_out,
	output logic [1:0] win_buf_out,
	output logic [1:0] filter_mode_out,
	output logic rx_load_out,
	output logic [2:0] abort_done_out,
	output logic [2:0] transmit_empty_flags_out,
	output logic init_mode_out
);
	logic [2:0] abort_req_reg, abort_req_next;
	logic [2:0] abort_ack_reg, abort_ack_next;
	logic [2:0] buf_sel_reg, buf_sel_next;
	logic [2:0] empty_reg, empty_next;
	logic [1:0] mode_reg, mode_next;
	logic [2:0] hit_reg, hit_next;
	logic init_req_reg;
	logic [1:0] init_cnt_reg;
	logic init_ack_reg;
	logic ready_reg;
	logic [2:0] started_reg;
	logic [2:0] rdata_next;
	logic [31:0] prdata_reg;

	// apb decode; one wait state so read data is settled at the ready edge
	wire apb_access = psel_in & penable_in;
	// writes land on the ready edge, reads load on the wait edge
	wire wr_en = apb_access & pwrite_in & ready_reg;
	wire rd_en = apb_access & ~pwrite_in & ~ready_reg;
	wire in_init = init_req_reg & init_ack_reg;
	wire not_init = ~init_req_reg & ~init_ack_reg;
	wire hit_req = paddr_in == can_ctrl_pkg::OFS_ABORT_REQ;
	wire hit_ack = paddr_in == can_ctrl_pkg::OFS_ABORT_ACK;
	wire hit_sel = paddr_in == can_ctrl_pkg::OFS_BUF_SEL;
	wire hit_flt = paddr_in == can_ctrl_pkg::OFS_FILT_CTRL;
	wire hit_emp = paddr_in == can_ctrl_pkg::OFS_EMPTY_FLAGS;
	wire hit_mod = paddr_in == can_ctrl_pkg::OFS_MODE_CTRL;
	wire mapped = hit_req | hit_ack | hit_sel | hit_flt | hit_emp | hit_mod;
	assign pready_out = ready_reg;
	assign pslverr_out = ready_reg & ~mapped;
	assign prdata_out = prdata_reg;

	// ready rises in the second access cycle, then drops for the next one
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ready_reg <= 1'b0;
		end else begin
			ready_reg <= apb_access & ~ready_reg;
		end
	end

	// lowest set select bit wins, higher bits ignored
	wire [2:0] sel_low = buf_sel_reg & (~buf_sel_reg + 3'h1);
	assign win_buf_out = sel_low[0] ? 2'h0 : (sel_low[1] ? 2'h1 : 2'h2);
	// window blocked when nothing selected or buffer scheduled
	assign win_allow_out = win_req_in & (|sel_low)
		& (|(sel_low & empty_reg));

	// grant: not yet started, or attempt failed
	wire [2:0] grantable = ~started_reg | tx_failed_in;
	wire [2:0] abort_grant = abort_req_reg & ~empty_reg & grantable
		& ~tx_success_in;
	assign abort_done_out = abort_grant;
	// empty flag set events: success or abort
	wire [2:0] empty_set = (tx_success_in | abort_grant) & ~empty_reg;
	wire [2:0] sw_clr = (wr_en & hit_emp & not_init) ? pwdata_in[2:0] : 3'h0;

	// next state of empty flags; set wins over software clear
	always_comb begin
		empty_next = (empty_reg & ~sw_clr) | empty_set;
		// abort request: software only sets, hardware clears
		abort_req_next = abort_req_reg;
		if (wr_en & hit_req & not_init) begin
			abort_req_next = abort_req_reg | (pwdata_in[2:0] & ~empty_reg);
		end
		abort_req_next = abort_req_next & ~empty_next;
		// acknowledge set by abort, cleared when empty flag cleared
		abort_ack_next = (abort_ack_reg & ~(sw_clr & ~empty_set))
			| abort_grant;
		buf_sel_next = buf_sel_reg;
		if (wr_en & hit_sel & not_init) begin
			buf_sel_next = pwdata_in[2:0];
		end
		mode_next = mode_reg;
		if (wr_en & hit_flt & in_init) begin
			mode_next = pwdata_in[can_ctrl_pkg::MODE_LSB +: 2];
		end
		hit_next = hit_reg;
		if (rx_load_out) begin
			hit_next = rx_filter_num_in;
		end
	end

	// closed filter never reloads the foreground buffer
	assign rx_load_out = rx_match_in
		& (mode_reg != can_ctrl_pkg::MODE_CLOSED);
	assign filter_mode_out = mode_reg;
	assign transmit_empty_flags_out = empty_reg;
	assign init_mode_out = in_init;

	// read mux; reserved bits read zero
	always_comb begin
		rdata_next = 3'h0;
		if (hit_req) rdata_next = abort_req_reg;
		if (hit_ack) rdata_next = abort_ack_reg;
		if (hit_sel) rdata_next = sel_low;
		if (hit_emp) rdata_next = empty_reg;
		if (hit_mod) rdata_next = {1'b0, init_ack_reg, init_req_reg};
	end

	// read data register, loaded on the access edge
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			prdata_reg <= 32'h0;
		end else if (rd_en) begin
			if (hit_flt)
				prdata_reg <= {26'h0, mode_reg, 1'b0, hit_reg};
			else
				prdata_reg <= {29'h0, rdata_next};
		end
	end

	// init request and delayed acknowledge
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			init_req_reg <= 1'b1;
			init_ack_reg <= 1'b1;
			init_cnt_reg <= 2'h0;
		end else begin
			if (wr_en & hit_mod)
				init_req_reg <= pwdata_in[can_ctrl_pkg::INIT_REQ_BIT];
			if (init_req_reg == init_ack_reg)
				init_cnt_reg <= 2'h0;
			else if (init_cnt_reg == 2'(can_ctrl_pkg::INIT_ACK_DELAY - 1)) begin
				init_ack_reg <= init_req_reg;
				init_cnt_reg <= 2'h0;
			end else
				init_cnt_reg <= init_cnt_reg + 2'h1;
		end
	end

	// transmit state registers; init holds them at reset
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			abort_req_reg <= can_ctrl_pkg::ABORT_REQ_RST;
			abort_ack_reg <= can_ctrl_pkg::ABORT_ACK_RST;
			buf_sel_reg <= can_ctrl_pkg::BUF_SEL_RST;
			empty_reg <= can_ctrl_pkg::EMPTY_RST;
			started_reg <= 3'h0;
		end else if (in_init) begin
			abort_req_reg <= can_ctrl_pkg::ABORT_REQ_RST;
			abort_ack_reg <= can_ctrl_pkg::ABORT_ACK_RST;
			buf_sel_reg <= can_ctrl_pkg::BUF_SEL_RST;
			empty_reg <= can_ctrl_pkg::EMPTY_RST;
			started_reg <= 3'h0;
		end else begin
			abort_req_reg <= abort_req_next;
			abort_ack_reg <= abort_ack_next;
			buf_sel_reg <= buf_sel_next;
			empty_reg <= empty_next;
			// a start sticks until the attempt ends
			started_reg <= (started_reg | tx_started_in)
				& ~tx_failed_in & ~empty_next;
		end
	end

	// filter control keeps its mode across init
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			mode_reg <= can_ctrl_pkg::MODE_RST;
			hit_reg <= can_ctrl_pkg::HIT_RST;
		end else begin
			mode_reg <= mode_next;
			hit_reg <= hit_next;
		end
	end

	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);

	// bus handshake: exactly one wait state per access
	a_ready_one_wait: assert property (
		(apb_access && !pready_out)
		|=> pready_out)
		else $error("ready missing after one wait");

	a_ready_in_access: assert property (
		pready_out
		|-> apb_access)
		else $error("ready raised outside an access");

	a_err_unmapped: assert property (
		pslverr_out
		|-> (pready_out && !mapped))
		else $error("error raised on a mapped access");

	// init mode holds the transmit registers at reset
	a_abort_init_hold: assert property (
		$past(in_init)
		|-> abort_req_reg == 3'h0)
		else $error("abort request not held in init");

	a_ack_init_hold: assert property (
		$past(in_init)
		|-> abort_ack_reg == 3'h0)
		else $error("acknowledge not held in init");

	a_sel_init_hold: assert property (
		$past(in_init)
		|-> buf_sel_reg == 3'h0)
		else $error("select not held in init");

	// abort grant and its flags
	a_grant_sets_flags: assert property (
		(!in_init && abort_grant != 3'h0)
		|=> ((empty_reg & abort_ack_reg) & $past(abort_grant))
		== $past(abort_grant))
		else $error("abort did not set empty and acknowledge");

	a_grant_needs_idle: assert property (
		abort_grant != 3'h0
		|-> (abort_grant & started_reg & ~tx_failed_in) == 3'h0)
		else $error("abort granted during running send");

	a_req_clears_empty: assert property (
		(abort_req_reg & empty_reg) == 3'h0)
		else $error("abort request alive with empty buffer");

	a_ack_follows_empty: assert property (
		(abort_ack_reg & ~empty_reg) == 3'h0)
		else $error("acknowledge set on scheduled buffer");

	a_req_readback: assert property (
		(rd_en && hit_req)
		|=> prdata_out == {29'h0, $past(abort_req_reg)})
		else $error("abort request readback wrong");

	// buffer select and access window
	a_sel_readback: assert property (
		(rd_en && hit_sel) |=> prdata_out[2:0] == $past(sel_low)
		&& $countones(prdata_out) <= 1)
		else $error("select readback not one-hot lowest");

	a_window_block: assert property (
		win_allow_out
		|-> (sel_low & empty_reg) != 3'h0)
		else $error("window open to scheduled buffer");

	a_win_none: assert property (
		sel_low == 3'h0
		|-> !win_allow_out)
		else $error("window open with nothing selected");

	a_win_buf_low: assert property (
		win_allow_out
		|-> (3'h1 << win_buf_out) == sel_low)
		else $error("window maps the wrong buffer");

	a_sel_write_lock: assert property (
		(wr_en && hit_sel && !not_init)
		|=> buf_sel_reg == $past(buf_sel_reg) || buf_sel_reg == 3'h0)
		else $error("select written outside normal mode");

	// acceptance filter control and hit field
	a_closed_no_load: assert property (
		mode_reg == can_ctrl_pkg::MODE_CLOSED
		|-> !rx_load_out)
		else $error("closed filter loaded a message");

	a_hit_update: assert property (
		rx_load_out
		|=> hit_reg == $past(rx_filter_num_in))
		else $error("hit field not updated on load");

	a_mode_locked: assert property (
		!in_init
		|=> mode_reg == $past(mode_reg))
		else $error("filter mode changed outside init");

	a_filt_write_init: assert property (
		(wr_en && hit_flt && in_init)
		|=> mode_reg == $past(pwdata_in[can_ctrl_pkg::MODE_LSB +: 2]))
		else $error("filter mode write lost in init");

	a_hit_readback: assert property (
		(rd_en && hit_flt)
		|=> prdata_out[2:0] == $past(hit_reg))
		else $error("hit field readback wrong");

	a_hit_hold: assert property (
		!rx_load_out
		|=> hit_reg == $past(hit_reg))
		else $error("hit field changed without a load");

	// per-buffer causes of request and acknowledge edges and of the empty flag rising
	for (genvar b = 0; b < 3; b++) begin : g_buf_chk
		a_req_set_by_sw: assert property (
			$rose(abort_req_reg[b])
			|-> $past(wr_en && hit_req && not_init && pwdata_in[b]))
			else $error("abort request set without a write");

		a_req_drop_cause: assert property (
			$fell(abort_req_reg[b])
			|-> empty_reg[b] || $past(in_init))
			else $error("abort request cleared while scheduled");

		a_ack_rise_cause: assert property (
			$rose(abort_ack_reg[b])
			|-> $past(abort_grant[b]))
			else $error("acknowledge set without an abort");

		a_ack_drop_cause: assert property (
			$fell(abort_ack_reg[b])
			|-> !empty_reg[b] || $past(in_init))
			else $error("acknowledge cleared while empty");

		a_empty_rise_cause: assert property (
			$rose(empty_reg[b])
			|-> $past(tx_success_in[b] || abort_grant[b] || in_init))
			else $error("empty flag set without a cause");

		a_done_pulse: assert property (
			abort_grant[b]
			|=> !abort_grant[b])
			else $error("abort granted twice in a row");
	end

	c_abort_done: cover property (abort_grant != 3'h0);
	c_send_ok: cover property (tx_success_in != 3'h0 && !in_init);
	c_window_ok: cover property (win_allow_out);
	c_rx_load: cover property (rx_load_out);
	c_win_blocked: cover property (win_req_in && sel_low != 3'h0
		&& !win_allow_out);
endmodule

/* File: test/can_bus_partner.sv */
`timescale 1ns/1ns
// far side stand-in: frame outcomes per buffer and received hits
module can_bus_partner (
	// clock
	input wire logic clk_in,
	// transmit outcome per buffer
	output logic [2:0] tx_started_out,
	output logic [2:0] tx_success_out,
	output logic [2:0] tx_failed_out,
	// receive hits
	output logic rx_match_out,
	output logic [2:0] rx_filter_num_out
);
	initial begin
		tx_started_out = 3'h0;
		tx_success_out = 3'h0;
		tx_failed_out = 3'h0;
		rx_match_out = 1'b0;
		rx_filter_num_out = 3'h5;
	end
	// a frame stays started until its outcome has been seen
	task start(input int b);
		@(posedge clk_in);
		tx_started_out[b] <= 1'b1;
	endtask
	// started held through the pulse so no false grant slips in
	task finish(input int b, input logic ok);
		@(posedge clk_in);
		tx_success_out[b] <= ok;
		tx_failed_out[b] <= !ok;
		@(posedge clk_in);
		tx_success_out <= 3'h0;
		tx_failed_out <= 3'h0;
		tx_started_out[b] <= 1'b0;
	endtask
	// number inverted once released, so a stale value never matches
	task rx(input logic [2:0] n, input int gap);
		repeat (gap) @(posedge clk_in);
		@(posedge clk_in);
		rx_match_out <= 1'b1;
		rx_filter_num_out <= n;
		@(posedge clk_in);
		rx_match_out <= 1'b0;
		rx_filter_num_out <= ~n;
	endtask
endmodule

/* File: test/can_tx_abort_select_filter_ctrl_tb.sv */
`timescale 1ns/1ns
module can_tx_abort_select_filter_ctrl_tb;
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
	logic win_req_in = 1'b0, err;
	logic [7:0] paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0, prdata_out, rdata;
	logic pready_out, pslverr_out, win_allow_out, rx_load_out;
	logic init_mode_out, rx_match_in;
	logic [1:0] win_buf_out, filter_mode_out;
	logic [2:0] tx_started_in, tx_success_in, tx_failed_in, v;
	logic [2:0] rx_filter_num_in, abort_done_out, transmit_empty_flags_out;
	int fail_count = 0, checks_done = 0, loads = 0, seed = 27;
	can_tx_abort_select_filter_ctrl u_can_tx_abort_select_filter_ctrl (
		.clk_in, .nrst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
		.pwdata_in, .prdata_out, .pready_out, .pslverr_out, .tx_started_in,
		.tx_success_in, .tx_failed_in, .rx_match_in, .rx_filter_num_in,
		.win_req_in, .win_allow_out, .win_buf_out, .filter_mode_out,
		.rx_load_out, .abort_done_out, .transmit_empty_flags_out,
		.init_mode_out);
	can_bus_partner u_can_bus_partner (.clk_in,
		.tx_started_out(tx_started_in), .tx_success_out(tx_success_in),
		.tx_failed_out(tx_failed_in), .rx_match_out(rx_match_in),
		.rx_filter_num_out(rx_filter_num_in));
	always #10 clk_in = ~clk_in;
	// foreground reloads counted here
	always @(posedge clk_in) if (rx_load_out === 1'b1) loads++;
	// request held until ready; answer taken at that same edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		err = pslverr_out;
		rdata = prdata_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdata, e);
	endtask
	function automatic logic [2:0] low1(input logic [2:0] x);
		return x & (~x + 3'h1);
	endfunction
	function automatic logic [1:0] idx(input logic [2:0] x);
		return x[0] ? 2'h0 : (x[1] ? 2'h1 : 2'h2);
	endfunction
	task stop_test;
		$display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// watchdog well beyond the expected few hundred cycles
	initial begin
		#200000;
		fail_count++;
		stop_test;
	end
	initial begin
		repeat (8) @(posedge clk_in);
		nrst_in <= 1'b1;
		rd(can_ctrl_pkg::OFS_ABORT_REQ, 32'h0);
		rd(can_ctrl_pkg::OFS_EMPTY_FLAGS, 32'h7);
		apb(1'b1, can_ctrl_pkg::OFS_BUF_SEL, 32'h1);
		rd(can_ctrl_pkg::OFS_BUF_SEL, 32'h0);
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, can_ctrl_pkg::OFS_FILT_CTRL, (m << 4) | 7);
			rd(can_ctrl_pkg::OFS_FILT_CTRL, m << 4);
			chk({30'h0, filter_mode_out}, 32'(m));
		end
		u_can_bus_partner.rx(3'h5, 0);
		rd(can_ctrl_pkg::OFS_FILT_CTRL, 32'h30);
		chk(loads, 0);
		apb(1'b1, can_ctrl_pkg::OFS_FILT_CTRL, 32'h10);
		apb(1'b1, can_ctrl_pkg::OFS_MODE_CTRL, 32'h0);
		repeat (4) @(posedge clk_in);
		chk({31'h0, init_mode_out}, 32'h0);
		apb(1'b1, can_ctrl_pkg::OFS_FILT_CTRL, 32'h20);
		rd(can_ctrl_pkg::OFS_FILT_CTRL, 32'h10);
		for (int i = 1; i < 9; i++) begin
			v = 3'($random(seed));
			u_can_bus_partner.rx(v, i % 3);
			rd(can_ctrl_pkg::OFS_FILT_CTRL, {28'h1, 1'b0, v});
			chk(loads, i);
		end
		win_req_in <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			v = (i < 2) ? 3'(i * 6) : 3'($random(seed));
			apb(1'b1, can_ctrl_pkg::OFS_BUF_SEL, {29'h0, v});
			rd(can_ctrl_pkg::OFS_BUF_SEL, {29'h0, low1(v)});
			chk({31'h0, win_allow_out}, 32'(v != 3'h0));
			if (v != 3'h0) chk({30'h0, win_buf_out}, {30'h0, idx(v)});
		end
		// all three scheduled, then one abort each way
		apb(1'b1, can_ctrl_pkg::OFS_EMPTY_FLAGS, 32'h7);
		apb(1'b1, can_ctrl_pkg::OFS_BUF_SEL, 32'h1);
		@(posedge clk_in);
		chk({31'h0, win_allow_out}, 32'h0);
		apb(1'b1, can_ctrl_pkg::OFS_ABORT_REQ, 32'h1);
		rd(can_ctrl_pkg::OFS_EMPTY_FLAGS, 32'h1);
		rd(can_ctrl_pkg::OFS_ABORT_ACK, 32'h1);
		rd(can_ctrl_pkg::OFS_ABORT_REQ, 32'h0);
		u_can_bus_partner.start(1);
		apb(1'b1, can_ctrl_pkg::OFS_ABORT_REQ, 32'h2);
		rd(can_ctrl_pkg::OFS_ABORT_REQ, 32'h2);
		u_can_bus_partner.finish(1, 1'b1);
		rd(can_ctrl_pkg::OFS_EMPTY_FLAGS, 32'h3);
		rd(can_ctrl_pkg::OFS_ABORT_ACK, 32'h1);
		rd(can_ctrl_pkg::OFS_ABORT_REQ, 32'h0);
		u_can_bus_partner.start(2);
		apb(1'b1, can_ctrl_pkg::OFS_ABORT_REQ, 32'h4);
		u_can_bus_partner.finish(2, 1'b0);
		rd(can_ctrl_pkg::OFS_EMPTY_FLAGS, 32'h7);
		rd(can_ctrl_pkg::OFS_ABORT_ACK, 32'h5);
		apb(1'b1, can_ctrl_pkg::OFS_ABORT_ACK, 32'h0);
		rd(can_ctrl_pkg::OFS_ABORT_ACK, 32'h5);
		apb(1'b1, can_ctrl_pkg::OFS_EMPTY_FLAGS, 32'h5);
		rd(can_ctrl_pkg::OFS_ABORT_ACK, 32'h0);
		rd(can_ctrl_pkg::OFS_EMPTY_FLAGS, 32'h2);
		apb(1'b1, can_ctrl_pkg::OFS_BUF_SEL, rdata);
		@(posedge clk_in);
		chk({30'h0, win_buf_out}, 32'h1);
		apb(1'b0, 8'h40, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, can_ctrl_pkg::OFS_MODE_CTRL, 32'h1);
		repeat (4) @(posedge clk_in);
		rd(can_ctrl_pkg::OFS_BUF_SEL, 32'h0);
		stop_test;
	end
endmodule
